// file: rtl/rail_ctrl_regs.vh
`ifndef RAIL_CTRL_REGS_VH
`define RAIL_CTRL_REGS_VH
// Register byte offsets
`define RAIL_CTRL_OFF 12'h000
`define RAIL_STATUS_OFF 12'h004
`define IRQ_STATUS_OFF 12'h008
`define IRQ_MASK_OFF 12'h00C
`define BTN_LEVEL_OFF 12'h010
// Button / event bit positions
`define BTN_USB 0
`define BTN_STANDBY 1
`define BTN_TV 2
`define BTN_RECORDER 3
`define BTN_STREAM 4
`define BTN_COUNT 5
// Rail bit positions in the rail status word
`define RAIL_USB 0
`define RAIL_FIRST_TUNER_RAIL 1
`define RAIL_SECOND_TUNER_RAIL 2
`define RAIL_THIRD_TUNER_RAIL 3
`define RAIL_HDMI 4
`define RAIL_DISK 5
`define RAIL_WIRELESS 6
`define RAIL_FRONT_END 7
`define RAIL_PROC_MEM 8
`define RAIL_COUNT 9
// Control register fields
`define CTRL_BTN_EN_BIT 0
`define CTRL_SW_PRESS_LSB 8
// Reset values
`define RAIL_CTRL_RESET 32'h00000001
`define IRQ_MASK_RESET 5'h00
// Debounce time in microseconds and derived count at 125 MHz
`define DEBOUNCE_US 20
`define CLK_MHZ 125
`define DEBOUNCE_CYCLES (`DEBOUNCE_US * `CLK_MHZ)
`endif

// file: rtl/button_sync.v
`default_nettype none
// Three-stage synchroniser and debounce for one active-low button.
// Emits a one-cycle press pulse on the falling edge of the settled level.
module button_sync #(
  parameter integer STABLE_CYCLES = 2500
) (
  input wire pclk,
  input wire presetn,
  input wire btn_n,
  output reg level_n,
  output reg press
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg [15:0] cnt_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      cnt_reg <= 16'h0000;
      level_n <= 1'b1;
      press <= 1'b0;
    end else begin
      s1_reg <= btn_n;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      press <= 1'b0;
      // Bounce restarts the count, so one press yields one event
      if ((s2_reg != s3_reg) || (s3_reg == level_n)) begin
        cnt_reg <= 16'h0000;
      end else if (cnt_reg == STABLE_CYCLES[15:0] - 16'h0001) begin
        cnt_reg <= 16'h0000;
        level_n <= s3_reg;
        press <= ~s3_reg;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule // button_sync
`default_nettype wire

// file: rtl/rail_mode_ctrl.v
// The address map and the APB register port were chosen for this implementation.
`include "rail_ctrl_regs.vh"
`default_nettype none
module rail_mode_ctrl #(
  parameter integer DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire usb_btn_n,
  input wire standby_btn_n,
  input wire tv_btn_n,
  input wire recorder_btn_n,
  input wire stream_btn_n,
  output reg usb_rail_en,
  output reg first_tuner_rail_en,
  output reg second_tuner_rail_en,
  output reg third_tuner_rail_en,
  output reg hdmi_rail_en,
  output reg disk_rail_en,
  output reg wireless_rail_en,
  output reg front_end_rail_en,
  output reg proc_mem_rail_en,
  output reg tv_mode,
  output reg recorder_mode,
  output reg stream_mode,
  output reg irq
);
  wire [`BTN_COUNT-1:0] btn_n;
  wire [`BTN_COUNT-1:0] level_n;
  wire [`BTN_COUNT-1:0] hw_press;
  reg [31:0] ctrl_reg;
  reg [`BTN_COUNT-1:0] irq_status_reg;
  reg [`BTN_COUNT-1:0] irq_mask_reg;
  reg [`BTN_COUNT-1:0] press;
  reg [`BTN_COUNT-1:0] irq_status_next;
  reg usb_next;
  reg first_tuner_rail_next;
  reg second_tuner_rail_next;
  reg third_tuner_rail_next;
  reg hdmi_next;
  reg disk_next;
  reg wireless_next;
  reg tv_next;
  reg rec_next;
  reg stream_next;
  reg [31:0] rdata_next;
  wire access_wr;
  wire setup_rd;
  wire addr_ok;
  wire [`BTN_COUNT-1:0] sw_press;

  assign btn_n = {stream_btn_n, recorder_btn_n, tv_btn_n, standby_btn_n, usb_btn_n};

  genvar i;
  generate
    for (i = 0; i < `BTN_COUNT; i = i + 1) begin : g_btn
      button_sync #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
      ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .btn_n(btn_n[i]),
        .level_n(level_n[i]),
        .press(hw_press[i])
      );
    end
  endgenerate

  // Zero-wait APB: every access completes in its access phase
  assign addr_ok = (paddr == `RAIL_CTRL_OFF) || (paddr == `RAIL_STATUS_OFF) ||
                   (paddr == `IRQ_STATUS_OFF) || (paddr == `IRQ_MASK_OFF) ||
                   (paddr == `BTN_LEVEL_OFF);
  // Writes commit at the edge that completes the access, never at setup
  assign access_wr = psel && penable && pwrite && pready;
  assign setup_rd = psel && !penable && !pwrite;
  // Software press strobes, self-clearing; useful when no buttons are fitted
  assign sw_press = (access_wr && paddr == `RAIL_CTRL_OFF) ?
                    pwdata[`CTRL_SW_PRESS_LSB +: `BTN_COUNT] : {`BTN_COUNT{1'b0}};

  always @* begin
    press = sw_press;
    if (ctrl_reg[`CTRL_BTN_EN_BIT]) begin
      press = press | hw_press;
    end
  end

  // Mode and rail next state
  always @* begin
    usb_next = usb_rail_en;
    first_tuner_rail_next = first_tuner_rail_en;
    second_tuner_rail_next = second_tuner_rail_en;
    third_tuner_rail_next = third_tuner_rail_en;
    hdmi_next = hdmi_rail_en;
    disk_next = disk_rail_en;
    wireless_next = wireless_rail_en;
    tv_next = tv_mode;
    rec_next = recorder_mode;
    stream_next = stream_mode;
    if (press[`BTN_USB]) begin
      usb_next = ~usb_rail_en;
    end
    // Standby outranks mode presses landing in the same cycle
    if (press[`BTN_STANDBY]) begin
      first_tuner_rail_next = 1'b0;
      second_tuner_rail_next = 1'b0;
      third_tuner_rail_next = 1'b0;
      hdmi_next = 1'b0;
      disk_next = 1'b0;
      wireless_next = 1'b0;
      tv_next = 1'b0;
      rec_next = 1'b0;
      stream_next = 1'b0;
    end else begin
      // Each mode toggles its own pair of rails; the common rails follow all three modes
      if (press[`BTN_TV]) begin
        first_tuner_rail_next = ~first_tuner_rail_en;
        hdmi_next = ~hdmi_rail_en;
        tv_next = ~hdmi_rail_en | ~first_tuner_rail_en;
      end
      if (press[`BTN_RECORDER]) begin
        second_tuner_rail_next = ~second_tuner_rail_en;
        disk_next = ~disk_rail_en;
        rec_next = ~disk_rail_en | ~second_tuner_rail_en;
      end
      if (press[`BTN_STREAM]) begin
        third_tuner_rail_next = ~third_tuner_rail_en;
        wireless_next = ~wireless_rail_en;
        stream_next = ~wireless_rail_en | ~third_tuner_rail_en;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_rail_en <= 1'b0;
      first_tuner_rail_en <= 1'b0;
      second_tuner_rail_en <= 1'b0;
      third_tuner_rail_en <= 1'b0;
      hdmi_rail_en <= 1'b0;
      disk_rail_en <= 1'b0;
      wireless_rail_en <= 1'b0;
      front_end_rail_en <= 1'b0;
      proc_mem_rail_en <= 1'b0;
      tv_mode <= 1'b0;
      recorder_mode <= 1'b0;
      stream_mode <= 1'b0;
    end else begin
      usb_rail_en <= usb_next;
      first_tuner_rail_en <= first_tuner_rail_next;
      second_tuner_rail_en <= second_tuner_rail_next;
      third_tuner_rail_en <= third_tuner_rail_next;
      hdmi_rail_en <= hdmi_next;
      disk_rail_en <= disk_next;
      wireless_rail_en <= wireless_next;
      tv_mode <= tv_next;
      recorder_mode <= rec_next;
      stream_mode <= stream_next;
      front_end_rail_en <= tv_next | rec_next | stream_next;
      proc_mem_rail_en <= tv_next | rec_next | stream_next;
    end
  end

  // Sticky event flags: a new press beats a simultaneous write-one clear
  always @* begin
    irq_status_next = irq_status_reg;
    if (access_wr && paddr == `IRQ_STATUS_OFF) begin
      irq_status_next = irq_status_next & ~pwdata[`BTN_COUNT-1:0];
    end
    irq_status_next = irq_status_next | press;
  end

  always @* begin
    case (paddr)
      `RAIL_CTRL_OFF: rdata_next = ctrl_reg;
      `RAIL_STATUS_OFF: rdata_next = {{(32-`RAIL_COUNT-3){1'b0}}, stream_mode, recorder_mode, tv_mode,
                                      proc_mem_rail_en, front_end_rail_en, wireless_rail_en, disk_rail_en,
                                      hdmi_rail_en, third_tuner_rail_en, second_tuner_rail_en,
                                      first_tuner_rail_en, usb_rail_en};
      `IRQ_STATUS_OFF: rdata_next = {{(32-`BTN_COUNT){1'b0}}, irq_status_reg};
      `IRQ_MASK_OFF: rdata_next = {{(32-`BTN_COUNT){1'b0}}, irq_mask_reg};
      `BTN_LEVEL_OFF: rdata_next = {{(32-`BTN_COUNT){1'b0}}, ~level_n};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RAIL_CTRL_RESET;
      irq_status_reg <= {`BTN_COUNT{1'b0}};
      irq_mask_reg <= `IRQ_MASK_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq <= |(irq_status_next & irq_mask_reg);
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (setup_rd) begin
        prdata <= rdata_next;
      end
      if (access_wr && paddr == `RAIL_CTRL_OFF) begin
        // Press strobes are not stored
        ctrl_reg <= {24'h000000, 7'h00, pwdata[`CTRL_BTN_EN_BIT]};
      end
      if (access_wr && paddr == `IRQ_MASK_OFF) begin
        irq_mask_reg <= pwdata[`BTN_COUNT-1:0];
      end
    end
  end
endmodule // rail_mode_ctrl
`default_nettype wire

// file: testbench/button_panel.sv
`default_nettype none
module button_panel (
  input wire logic pclk,
  input wire logic [4:0] hold,
  output logic [4:0] btn_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] prev1 = 5'h00;
  logic [4:0] prev2 = 5'h00;
  always @(posedge pclk) begin
    prev1 <= hold;
    prev2 <= prev1;
  end
  // Pull-up when idle; one chatter blip after first touch
  assign btn_n = ~hold | (prev1 & ~prev2);
endmodule // button_panel
`default_nettype wire

// file: testbench/rail_mode_ctrl_assertions.sv
`default_nettype none
module rail_mode_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic usb_rail_en,
  input wire logic first_tuner_rail_en,
  input wire logic second_tuner_rail_en,
  input wire logic third_tuner_rail_en,
  input wire logic hdmi_rail_en,
  input wire logic disk_rail_en,
  input wire logic wireless_rail_en,
  input wire logic front_end_rail_en,
  input wire logic proc_mem_rail_en,
  input wire logic tv_mode,
  input wire logic recorder_mode,
  input wire logic stream_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  common_rails_a: assert property ((tv_mode | recorder_mode | stream_mode) == front_end_rail_en
    && proc_mem_rail_en == front_end_rail_en) else $error("common rails disagree with modes");
  tv_pair_a: assert property (first_tuner_rail_en == hdmi_rail_en && tv_mode == hdmi_rail_en)
    else $error("tv rails out of step");
  recorder_pair_a: assert property (second_tuner_rail_en == disk_rail_en && recorder_mode == disk_rail_en)
    else $error("recorder rails out of step");
  stream_pair_a: assert property (third_tuner_rail_en == wireless_rail_en && stream_mode == wireless_rail_en)
    else $error("stream rails out of step");
  standby_usb_a: assert property ($fell(front_end_rail_en) |-> $stable(usb_rail_en))
    else $error("usb rail moved with standby");
  modes_indep_a: assert property ($rose(tv_mode) |-> $stable({recorder_mode, stream_mode}))
    else $error("tv mode disturbed other modes");
  access_ready_a: assert property (psel && !penable |=> pready) else $error("no ready in access cycle");
  ready_single_a: assert property (pready |=> !pready) else $error("ready held two cycles");
endmodule // rail_mode_checker
bind rail_mode_ctrl rail_mode_checker checker_i (.*);
`default_nettype wire

// file: testbench/rail_mode_ctrl_tb.sv
`include "rail_ctrl_regs.vh"
`default_nettype none
module rail_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, q;
  logic [4:0] hold = 5'h00, mask = 5'h00;
  logic [3:0] m = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [4:0] btn_n;
  wire [11:0] rails;
  int err_count = 0;
  int n_compared = 0;
  int seq[7] = '{2, 3, 4, 0, 1, 0, 2};
  always #4 pclk = ~pclk;
  button_panel panel (.pclk(pclk), .hold(hold), .btn_n(btn_n));
  rail_mode_ctrl #(.DEBOUNCE_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_btn_n(btn_n[0]), .standby_btn_n(btn_n[1]), .tv_btn_n(btn_n[2]), .recorder_btn_n(btn_n[3]),
    .stream_btn_n(btn_n[4]), .usb_rail_en(rails[0]), .first_tuner_rail_en(rails[1]),
    .second_tuner_rail_en(rails[2]), .third_tuner_rail_en(rails[3]), .hdmi_rail_en(rails[4]),
    .disk_rail_en(rails[5]), .wireless_rail_en(rails[6]), .front_end_rail_en(rails[7]),
    .proc_mem_rail_en(rails[8]), .tv_mode(rails[9]), .recorder_mode(rails[10]), .stream_mode(rails[11]),
    .irq(irq));
  // Model bits: usb, tv, recorder, stream
  function logic [11:0] expect_rails(input logic [3:0] s);
    return {s[3:1], |s[3:1], |s[3:1], s[3:1], s[3:1], s[0]};
  endfunction
  task results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    serr = pslverr;
    if (n >= 20) err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task press(input int b);
    hold[b] <= 1'b1;
    repeat (20) @(posedge pclk);
    hold[b] <= 1'b0;
    repeat (20) @(posedge pclk);
    if (b == 1) m[3:1] = 3'h0;
    else if (b == 0) m[0] = ~m[0];
    else m[b - 1] = ~m[b - 1];
    chk("rails", expect_rails(m), rails);
    apb(1'b0, `RAIL_STATUS_OFF, 32'h0);
    chk("rail_status", expect_rails(m), q);
    chk("status_err", 1'b0, serr);
    apb(1'b0, `IRQ_STATUS_OFF, 32'h0);
    chk("irq_status", 32'h1 << b, q);
    chk("irq", mask[b], irq);
    apb(1'b1, `IRQ_STATUS_OFF, 32'h1F);
    repeat (2) @(posedge pclk);
    chk("irq_clear", 1'b0, irq);
  endtask
  initial begin
    void'($urandom(32'hD3FF));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("rails_reset", 12'h000, rails);
    apb(1'b0, `RAIL_CTRL_OFF, 32'h0);
    chk("ctrl_reset", `RAIL_CTRL_RESET, q);
    apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
    chk("unmapped_err", 1'b1, serr);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped_data", 32'h0, q);
    mask = 5'h1F;
    apb(1'b1, `IRQ_MASK_OFF, {27'h0, mask});
    // All three modes on together, then standby with usb on
    foreach (seq[i]) press(seq[i]);
    repeat (16) begin
      mask = 5'($urandom);
      apb(1'b1, `IRQ_MASK_OFF, {27'h0, mask});
      press($urandom % 5);
    end
    // Pins disabled: software strobe still acts, a held pin only shows as a level
    apb(1'b1, `RAIL_CTRL_OFF, 32'h1 << (`CTRL_SW_PRESS_LSB + `BTN_TV));
    m[1] = ~m[1];
    repeat (2) @(posedge pclk);
    chk("sw_press", expect_rails(m), rails);
    hold[`BTN_RECORDER] <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b0, `BTN_LEVEL_OFF, 32'h0);
    chk("btn_level", 32'h1 << `BTN_RECORDER, q);
    hold[`BTN_RECORDER] <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("btn_disabled", expect_rails(m), rails);
    apb(1'b0, `IRQ_STATUS_OFF, 32'h0);
    chk("sw_irq_status", 32'h1 << `BTN_TV, q);
    apb(1'b0, `RAIL_CTRL_OFF, 32'h0);
    chk("ctrl_off", 32'h0, q);
    results();
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule // rail_mode_ctrl_tb
`default_nettype wire
